// ---- logic/ee_dev.sv ----
/*
  Slave end of a 2 Kbit two-wire EEPROM: addressing, page buffer, self-timed
  write, write protection, acknowledge polling and all read forms.
  Assumes a master that makes SCL, Start and Stop; all link pins are
  asynchronous to clock_i and are synchronised here.
*/
// Notes on behaviour
// - Up to 8 data bytes buffered until Stop
// - Only low three pointer bits increment on writes
// - Extra bytes wrap, overwriting earlier buffered ones
// - Stop after write starts timed write
// - Master keeps page writes inside one page
// - Writes to 80h-FFh silently ignored
// - 00h-7Fh freely written and read
// - No acknowledge while write cycle runs
// - Master may poll right after Stop
// - Direction bit one selects device transmit
// - Pointer holds last address plus one
// - Master nack then Stop ends read
// - Word address latched before repeated Start
// - Master ack requests next sequential byte
// - Pointer advances after every read byte
// - Low supply at Stop or at write cycle end blocks programming
// - Node address readable at FAh to FFh
// - Host inserts FFFEh for 64-bit form
// - Respond only to control code 1010
// - First write byte loads the pointer
`timescale 1ns/1ps
`default_nettype none
module ee_dev import ee_pkg::*; #(
  parameter int WR_CYC_P = WR_CYC,
  parameter logic [47:0] NODE_ADDR = 48'h0A1B2C3D4E5F, // Arbitrary value
  parameter bit SELECT_EN = 1'b0
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  ee_if.dev link,
  input wire logic chip_select_pin_bit0_i,
  input wire logic chip_select_pin_bit1_i,
  input wire logic chip_select_pin_bit2_i,
  input wire logic supply_low_i,
  output logic busy_o
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic sda_m;
    logic sda_s;
    logic sda_q;
    logic [2:0] sel_m;
    logic [2:0] sel_s;
    logic low_m;
    logic low_s;
    ee_dst_t st;
    logic [3:0] bitn;
    logic [7:0] sr;
    logic [7:0] txb;
    logic [7:0] ptr;
    logic mack;
    logic oe_n;
    logic [PAGE_SIZE-1:0][7:0] pbuf;
    logic [PAGE_SIZE-1:0] bvalid;
    logic [7-PAGE_BITS:0] page;
    logic busy;
    logic [TMR_W-1:0] timer;
    logic commit;
  } ee_dev_st_t;

  ee_dev_st_t s;
  ee_dev_st_t n;
  logic [7:0] mem [0:127];
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic ctrl_hit;
  logic [7:0] rd_byte;
  logic [2:0] nidx;

  // Bus conditions seen on the synchronised pins
  assign rise = s.scl_s & ~s.scl_q;
  assign fall = ~s.scl_s & s.scl_q;
  assign start = s.scl_s & s.scl_q & s.sda_q & ~s.sda_s;
  assign stop = s.scl_s & s.scl_q & ~s.sda_q & s.sda_s;
  assign ctrl_hit = (s.sr[7:4] == CTRL_CODE) && (!SELECT_EN || s.sr[3:1] == s.sel_s);

  // Byte at the pointer: node address, blank protected half, or the array
  assign nidx = 3'(NODE_TOP - s.ptr);
  always_comb begin
    if (s.ptr >= NODE_BASE) begin
      rd_byte = NODE_ADDR[{nidx, 3'h0} +: 8];
    end else if (s.ptr[PROT_BIT]) begin
      rd_byte = BLANK_BYTE;
    end else begin
      rd_byte = mem[s.ptr[6:0]];
    end
  end

  // Next-state logic for the whole engine
  always_comb begin
    n = s;
    n.scl_m = link.scl;
    n.scl_s = s.scl_m;
    n.scl_q = s.scl_s;
    n.sda_m = link.sda;
    n.sda_s = s.sda_m;
    n.sda_q = s.sda_s;
    n.sel_m = {chip_select_pin_bit2_i, chip_select_pin_bit1_i, chip_select_pin_bit0_i};
    n.sel_s = s.sel_m;
    n.low_m = supply_low_i;
    n.low_s = s.low_m;
    n.commit = 1'b0;
    if (s.commit) begin
      n.bvalid = '0;
    end
    // Self-timed write cycle; a supply dip at its end discards the page
    if (s.busy) begin
      if (s.timer == TMR_W'(WR_CYC_P - 1)) begin
        n.busy = 1'b0;
        n.timer = '0;
        n.commit = ~s.low_s;
      end else begin
        n.timer = s.timer + 1'b1;
      end
    end
    if (start) begin
      // Repeated Start drops an unfinished page but keeps the pointer
      n.st = EE_DS_CTRL;
      n.bitn = '0;
      n.oe_n = 1'b1;
      if (!s.busy) begin
        n.bvalid = '0;
      end
    end else if (stop) begin
      n.st = EE_DS_IDLE;
      n.oe_n = 1'b1;
      if (s.st == EE_DS_WDATA && |s.bvalid && !s.low_s && !s.busy) begin
        n.busy = 1'b1;
        n.timer = '0;
      end
    end else if (s.st != EE_DS_IDLE) begin
      if (rise && s.bitn != ACK_END) begin
        n.bitn = s.bitn + 1'b1;
        if (s.bitn < ACK_SLOT) begin
          n.sr = {s.sr[6:0], s.sda_s};
        end else begin
          n.mack = ~s.sda_s;
        end
      end
      if (fall) begin
        if (s.bitn == ACK_SLOT) begin
          // Acknowledge slot opens
          n.oe_n = 1'b1;
          case (s.st)
            EE_DS_CTRL: begin
              if (ctrl_hit && !s.busy) begin
                n.oe_n = 1'b0;
              end else begin
                n.st = EE_DS_SKIP;
              end
            end
            EE_DS_ADDR: begin
              n.oe_n = 1'b0;
              n.ptr = s.sr;
              n.page = s.sr[7:PAGE_BITS];
            end
            EE_DS_WDATA: begin
              n.oe_n = 1'b0;
              n.pbuf[s.ptr[PAGE_BITS-1:0]] = s.sr;
              n.bvalid[s.ptr[PAGE_BITS-1:0]] = 1'b1;
              n.ptr = {s.ptr[7:PAGE_BITS], s.ptr[PAGE_BITS-1:0] + 3'h1};
            end
            default: begin
            end
          endcase
        end else if (s.bitn == ACK_END) begin
          // Acknowledge slot closes; set up the next byte
          n.bitn = '0;
          n.oe_n = 1'b1;
          case (s.st)
            EE_DS_CTRL: begin
              if (s.sr[0]) begin
                n.st = EE_DS_RDATA;
                n.txb = rd_byte;
                n.oe_n = rd_byte[7];
                n.ptr = s.ptr + 8'h01;
              end else begin
                n.st = EE_DS_ADDR;
              end
            end
            EE_DS_ADDR: n.st = EE_DS_WDATA;
            EE_DS_RDATA: begin
              if (s.mack) begin
                n.txb = rd_byte;
                n.oe_n = rd_byte[7];
                n.ptr = s.ptr + 8'h01;
              end else begin
                n.st = EE_DS_SKIP;
              end
            end
            default: begin
            end
          endcase
        end else if (s.st == EE_DS_RDATA) begin
          n.oe_n = s.txb[3'h7 - s.bitn[2:0]];
        end
      end
    end
  end

  // State register; pins idle high so reset shows no false edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_q <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_q <= 1'b1;
      s.st <= EE_DS_IDLE;
      s.oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Array programming; the protected half has no storage to write
  always_ff @(posedge clock_i) begin
    if (s.commit) begin
      for (int i = 0; i < PAGE_SIZE; i++) begin
        if (s.bvalid[i] && !s.page[7-PAGE_BITS]) begin
          mem[{s.page[6-PAGE_BITS:0], 3'(i)}] <= s.pbuf[i];
        end
      end
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = s.oe_n;
  assign busy_o = s.busy;
endmodule : ee_dev
`default_nettype wire

// ---- logic/ee_host.sv ----
/*
  Two-wire bus master: makes SCL by a divider and runs one bus primitive
  (Start, Stop, write byte, read byte) per command.
  Assumes a single open-drain slave; SDA arrives asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module ee_host import ee_pkg::*; (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  ee_if.host link,
  input wire logic cmd_valid_i,
  input wire ee_cmd_t cmd_i,
  input wire logic [7:0] wbyte_i,
  input wire logic mack_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rbyte_o,
  output logic nack_o
);
  typedef struct packed {
    logic sda_m;
    logic sda_s;
    ee_hst_t st;
    ee_cmd_t cmd;
    logic [1:0] qc;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic mack;
    logic scl;
    logic oe_n;
    logic done;
    logic [7:0] rbyte;
    logic nack;
  } ee_host_st_t;

  ee_host_st_t s;
  ee_host_st_t n;
  logic v1;
  logic v3;
  logic last;

  // Line level for the current bit: v1 while SCL rises, v3 late in high
  always_comb begin
    v1 = 1'b1;
    v3 = 1'b1;
    case (s.cmd)
      EE_CMD_START: v3 = 1'b0;
      EE_CMD_STOP: v1 = 1'b0;
      EE_CMD_WRITE: begin
        v1 = (s.bitn == ACK_SLOT) ? 1'b1 : s.sh[7];
        v3 = v1;
      end
      default: begin
        v1 = (s.bitn == ACK_SLOT) ? ~s.mack : 1'b1;
        v3 = v1;
      end
    endcase
  end
  assign last = (s.cmd == EE_CMD_START || s.cmd == EE_CMD_STOP) || (s.bitn == ACK_SLOT);

  // Quarter-period sequencer; SDA only moves in the second quarter (SCL low)
  // or last quarter (SCL high, Start or Stop)
  always_comb begin
    n = s;
    n.sda_m = link.sda;
    n.sda_s = s.sda_m;
    n.done = 1'b0;
    case (s.st)
      EE_HS_IDLE: begin
        if (cmd_valid_i) begin
          n.st = EE_HS_RUN;
          n.cmd = cmd_i;
          n.sh = wbyte_i;
          n.mack = mack_i;
          n.qc = '0;
          n.q = '0;
          n.bitn = '0;
          n.scl = 1'b0;
        end
      end
      EE_HS_RUN: begin
        if (s.qc == 2'(SCL_QTR_CYC - 1)) begin
          n.qc = '0;
          n.q = s.q + 2'h1;
          case (s.q)
            2'h0: n.oe_n = v1;
            2'h1: n.scl = 1'b1;
            2'h2: n.oe_n = v3;
            default: begin
              // Sample at the end of SCL high
              if (s.bitn < ACK_SLOT) begin
                n.sh = {s.sh[6:0], s.sda_s};
              end
              if (last) begin
                n.st = EE_HS_IDLE;
                n.done = 1'b1;
                n.nack = (s.cmd == EE_CMD_WRITE) ? s.sda_s : 1'b0;
                if (s.cmd == EE_CMD_READ) begin
                  n.rbyte = s.sh;
                end
              end else begin
                n.bitn = s.bitn + 1'b1;
                n.scl = 1'b0;
              end
            end
          endcase
        end else begin
          n.qc = s.qc + 2'h1;
        end
      end
      default: n.st = EE_HS_IDLE;
    endcase
  end

  // State register; bus idles with both lines released high
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.st <= EE_HS_IDLE;
      s.cmd <= EE_CMD_START;
      s.scl <= 1'b1;
      s.oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.scl = s.scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = s.oe_n;
  assign cmd_ready_o = (s.st == EE_HS_IDLE);
  assign done_o = s.done;
  assign rbyte_o = s.rbyte;
  assign nack_o = s.nack;
endmodule : ee_host
`default_nettype wire

// ---- logic/ee_if.sv ----
/*
  Two-wire link between the EEPROM engine and its master.
  Assumes open-drain data with a pull-up; the clock is driven by the master only.
*/
`timescale 1ns/1ps
`default_nettype none
interface ee_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // Wired-AND with pull-up: a released end reads high
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface : ee_if
`default_nettype wire

// ---- logic/ee_pkg.sv ----
/*
  Shared constants and types for the serial EEPROM access engine and its
  bus master. Assumes a 50 MHz system clock on both ends.
*/
`default_nettype none
package ee_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 20;
  // Addressing byte
  localparam logic [3:0] CTRL_CODE = 4'hA;
  // Page buffer geometry
  localparam int PAGE_SIZE = 8;
  localparam int PAGE_BITS = 3;
  // Array map
  localparam logic [7:0] NODE_BASE = 8'hFA;
  localparam logic [7:0] NODE_TOP = 8'hFF;
  localparam int PROT_BIT = 7;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  // Self-timed write cycle
  localparam int WR_TIME_NS = 1000000;
  localparam int WR_CYC = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 20;
  // Link clock made by the master
  localparam int SCL_PERIOD_NS = 160;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Bit slots within a byte
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_END = 4'h9;

  // Device bus states
  typedef enum logic [5:0] {
    EE_DS_IDLE = 6'h01,
    EE_DS_CTRL = 6'h02,
    EE_DS_ADDR = 6'h04,
    EE_DS_WDATA = 6'h08,
    EE_DS_RDATA = 6'h10,
    EE_DS_SKIP = 6'h20
  } ee_dst_t;

  // Master states
  typedef enum logic [1:0] {
    EE_HS_IDLE = 2'h1,
    EE_HS_RUN = 2'h2
  } ee_hst_t;

  // Master commands
  typedef enum logic [1:0] {
    EE_CMD_START = 2'h0,
    EE_CMD_STOP = 2'h1,
    EE_CMD_WRITE = 2'h2,
    EE_CMD_READ = 2'h3
  } ee_cmd_t;
endpackage : ee_pkg
`default_nettype wire

// ---- tb/ee_checker.sv ----
/*
  Wire-level checks of the EEPROM link and its self-timed write cycle.
  Assumes it sits beside the link interface in the bench, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ee_checker #(
  parameter int WR_CYC_P = 20
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic dev_sda_oe_n_i,
  input wire logic busy_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  logic [15:0] busy_cnt;
  logic [3:0] stop_age;
  logic sda_q;

  // Cycles since the last Stop, saturating so it never wraps back to a match
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      busy_cnt <= 16'h0000;
      stop_age <= 4'hF;
      sda_q <= 1'h1;
    end else begin
      busy_cnt <= busy_i ? busy_cnt + 16'h0001 : 16'h0000;
      sda_q <= sda_i;
      if (scl_i && sda_i && !sda_q) begin
        stop_age <= 4'h0;
      end else if (stop_age != 4'hF) begin
        stop_age <= stop_age + 4'h1;
      end
    end
  end

  chk_busy_quiet: assert property (busy_i |-> dev_sda_oe_n_i)
    else $error("device pulled data during write cycle");
  chk_busy_cause: assert property ($rose(busy_i) |-> stop_age <= 4'h8)
    else $error("write cycle began without a recent Stop");
  chk_busy_length: assert property ($fell(busy_i) |-> busy_cnt == 16'(WR_CYC_P))
    else $error("write cycle length wrong");
  chk_busy_min: assert property ($rose(busy_i) |-> busy_i [*8])
    else $error("write cycle cut short");
  chk_dev_edge: assert property ($changed(dev_sda_oe_n_i) |-> !scl_i)
    else $error("device changed data while clock high");
  chk_dev_hold: assert property ($fell(dev_sda_oe_n_i) |-> !dev_sda_oe_n_i [*8])
    else $error("device released a driven bit early");
  chk_scl_low: assert property ($fell(scl_i) |-> !scl_i [*4])
    else $error("link clock low phase too short");
  chk_scl_high: assert property ($rose(scl_i) |-> scl_i [*4])
    else $error("link clock high phase too short");
endmodule : ee_checker
`default_nettype wire

// ---- tb/serial_eeprom_access_engine_tb.sv ----
/*
  Bench joining master and EEPROM ends over the link; a byte model predicts
  every read. Assumes the package and interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module serial_eeprom_access_engine_tb;
  import ee_pkg::*;
  localparam int WRC = 200;
  localparam logic [47:0] NODE = 48'h5A6B7C8D9EAF; // Arbitrary value
  logic clock_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic valid = 1'h0;
  logic mack = 1'h0;
  logic low_sup = 1'h0;
  logic [2:0] sel = 3'h0;
  ee_cmd_t cmd = EE_CMD_STOP;
  logic [7:0] wb = 8'h00;
  localparam logic [15:0] ID_FILL = 16'hFFFE;
  logic busy, done, nack, rdy;
  logic [47:0] node_rd = 48'h000000000000;
  logic [7:0] rb, ptr;
  logic [7:0] mem [256];
  int err_count = 0;
  int total_checks = 0;

  ee_if lnk();
  ee_dev #(.WR_CYC_P(WRC), .NODE_ADDR(NODE)) i_ee_dev(.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .link(lnk), .chip_select_pin_bit0_i(sel[0]),
    .chip_select_pin_bit1_i(sel[1]), .chip_select_pin_bit2_i(sel[2]),
    .supply_low_i(low_sup), .busy_o(busy));
  ee_host i_ee_host(.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(lnk),
    .cmd_valid_i(valid), .cmd_i(cmd), .wbyte_i(wb), .mack_i(mack), .cmd_ready_o(rdy),
    .done_o(done), .rbyte_o(rb), .nack_o(nack));
  ee_checker #(.WR_CYC_P(WRC)) u_chk(.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .scl_i(lnk.scl), .sda_i(lnk.sda), .dev_sda_oe_n_i(lnk.dev_sda_oe_n), .busy_i(busy));

  // 50 MHz system clock
  initial begin
    forever #10 clock_i = ~clock_i;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // One bus primitive; held until the accept edge, then bounded wait on done
  task automatic op(input ee_cmd_t c, input logic [7:0] b, input logic m);
    int n;
    n = 0;
    @(negedge clock_i);
    `CHK(rdy, 1'h1)
    cmd = c;
    wb = b;
    mack = m;
    valid = 1'h1;
    @(negedge clock_i);
    valid = 1'h0;
    `CHK(rdy, 1'h0)
    while (done !== 1'h1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 100) begin
      err_count++;
      $display("[ERR] %0t no done", $time);
      print_verdict();
    end
  endtask : op

  // Page write of n random bytes, then acknowledge polling
  task automatic wr(input logic [7:0] a, input int n, input logic chk);
    logic [7:0] ad [$];
    logic [7:0] dt [$];
    logic [7:0] d;
    int k;
    op(EE_CMD_START, 8'h00, 1'h0);
    op(EE_CMD_WRITE, 8'hA0, 1'h0);
    `CHK(nack, 1'h0)
    op(EE_CMD_WRITE, a, 1'h0);
    `CHK(nack, 1'h0)
    for (k = 0; k < n; k++) begin
      d = 8'($urandom);
      ad.push_back({a[7:3], 3'(a[2:0] + k)});
      dt.push_back(d);
      op(EE_CMD_WRITE, d, 1'h0);
      `CHK(nack, 1'h0)
    end
    ptr = {a[7:3], 3'(a[2:0] + n)};
    op(EE_CMD_STOP, 8'h00, 1'h0);
    if (!a[7] && !low_sup) foreach (ad[i]) mem[ad[i]] = dt[i];
    // First poll lands inside the write cycle
    for (k = 0; k < 30; k++) begin
      op(EE_CMD_START, 8'h00, 1'h0);
      op(EE_CMD_WRITE, 8'hA0, 1'h0);
      if (k == 0 && chk) `CHK(nack, 1'h1)
      if (nack === 1'h0) break;
      op(EE_CMD_STOP, 8'h00, 1'h0);
    end
    `CHK(nack, 1'h0)
    `CHK(busy, 1'h0)
    op(EE_CMD_STOP, 8'h00, 1'h0);
  endtask : wr

  // Random read when a >= 0, else current address read; n bytes in a row
  task automatic rd(input int a, input int n);
    int k;
    op(EE_CMD_START, 8'h00, 1'h0);
    if (a >= 0) begin
      op(EE_CMD_WRITE, 8'hA0, 1'h0);
      op(EE_CMD_WRITE, 8'(a), 1'h0);
      ptr = 8'(a);
      op(EE_CMD_START, 8'h00, 1'h0);
    end
    op(EE_CMD_WRITE, 8'hA1, 1'h0);
    `CHK(nack, 1'h0)
    for (k = 0; k < n; k++) begin
      op(EE_CMD_READ, 8'h00, 1'(k < n - 1));
      `CHK(rb, mem[ptr])
      node_rd = {node_rd[39:0], rb};
      ptr++;
    end
    op(EE_CMD_STOP, 8'h00, 1'h0);
  endtask : rd

  // Main sequence
  initial begin
    int k;
    logic [7:0] d;
    sel = 3'($urandom(12));
    for (k = 32'h80; k < 32'hFA; k++) mem[k] = BLANK_BYTE;
    for (k = 0; k < 6; k++) mem[32'hFA + k] = NODE[47 - 8 * k -: 8];
    repeat (5) @(negedge clock_i);
    sys_rst_i = 1'h0;
    wr(8'h04, 10, 1'h1);
    rd(-1, 1);
    rd(32'hFA, 13);
    rd(-1, 1);
    // Node address read back and widened the way host software does it
    rd(32'hFA, 6);
    `CHK({node_rd[47:24], ID_FILL, node_rd[23:0]}, {NODE[47:24], ID_FILL, NODE[23:0]})
    wr(8'h85, 2, 1'h0);
    rd(32'h84, 3);
    // A protected page must not alias onto the writable half
    rd(32'h05, 2);
    // Low supply must leave the array untouched
    low_sup = 1'h1;
    wr(8'h02, 1, 1'h0);
    low_sup = 1'h0;
    rd(32'h02, 1);
    // Foreign control codes are ignored
    for (k = 0; k < 3; k++) begin
      d = 8'($urandom);
      if (d[7:4] == CTRL_CODE) d[7] = 1'h0;
      op(EE_CMD_START, 8'h00, 1'h0);
      op(EE_CMD_WRITE, d, 1'h0);
      `CHK(nack, 1'h1)
      op(EE_CMD_STOP, 8'h00, 1'h0);
    end
    print_verdict();
  end
endmodule : serial_eeprom_access_engine_tb
`default_nettype wire
